// [rtl/spcfg_top.sv]
// module: serial port unit with mode and frame configuration
//
// Contract
// - enable bit hands the four pins to port
// - master drives clock pin, slave receives it
// - clock release stops clock, frees pin
// - data-out release leaves output pin undriven
// - width bit selects 16 or 8 bits
// - sample at end or middle of bit
// - edge bit picks output change transition; code uses it in unframed master only, slave changes on trailing edge
// - select enable uses active-low select pin
// - polarity bit sets clock idle level
// - master bit picks master or slave
// - secondary divider 1 to 8 by code
// - primary divider 1,4,16,64 by code
// - framed mode turns select into frame pulse
// - frame direction: input slave, output master
// - frame polarity high or low active
// - frame pulse with or before first bit; code ignores the edge bit, pulse always with first bit
// - unimplemented bits read zero
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module spcfg_top (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  output logic sdo_out,
  output logic sdo_oe_n,
  input wire logic sdi_in,
  input wire logic sel_in,
  output logic sel_out,
  output logic sel_oe_n
);
  import spcfg_pkg::*;
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [15:0] one_reg, one_next; // control one
  logic [15:0] two_reg, two_next; // control two
  logic en_reg, en_next; // module enable
  logic [15:0] tx_reg, tx_next; // word to send
  logic [15:0] rx_reg, rx_next; // last word received
  logic rxf_reg, rxf_next; // receive full
  logic [15:0] rdata_next;
  // named fields
  logic master, width16, input_sample_phase, edge_sel, sel_en, cpol, clk_rel, dout_rel;
  logic frm_en, frm_dir, frm_pol, frm_edge;
  assign master = one_reg[MASTER_BIT];
  assign width16 = one_reg[WIDTH_BIT];
  assign input_sample_phase = one_reg[SMP_BIT];
  assign edge_sel = one_reg[EDGE_BIT] & ~frm_en;
  assign sel_en = one_reg[SEL_EN_BIT];
  assign cpol = one_reg[POL_BIT];
  assign clk_rel = one_reg[CLK_REL_BIT];
  assign dout_rel = one_reg[DOUT_REL_BIT];
  assign frm_en = two_reg[FRM_EN_BIT];
  assign frm_dir = two_reg[FRM_DIR_BIT];
  assign frm_pol = two_reg[FRM_POL_BIT];
  assign frm_edge = two_reg[FRM_EDGE_BIT];
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] sy1_reg, sy2_reg; // clock, data in, select
  logic sck_d_reg; // previous synchronised clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      // select pin idles high; a low here would fake a select
      sy1_reg <= 3'h1;
      sy2_reg <= 3'h1;
      sck_d_reg <= 1'b0;
    end else begin
      sy1_reg <= {sck_in, sdi_in, sel_in};
      sy2_reg <= sy1_reg;
      sck_d_reg <= sy2_reg[2];
    end
  end
  logic s_sck, s_sdi, s_sel;
  assign s_sck = sy2_reg[2];
  assign s_sdi = sy2_reg[1];
  assign s_sel = sy2_reg[0];
  // ---------------------------------------------------------------
  // transfer engine
  // ---------------------------------------------------------------
  logic busy_reg, busy_next; // transfer running
  logic [5:0] ph_reg, ph_next; // half bit phase count
  logic [15:0] sh_reg, sh_next; // shift register
  logic sck_reg, sck_next; // generated clock level (active = 1)
  logic sdo_reg, sdo_next;
  logic fs_reg, fs_next; // frame pulse asserted
  logic pend_reg, pend_next; // sample deferred to end of bit
  logic tick; // half bit enable
  logic [5:0] last_ph; // final half bit index
  logic lead, trail, act_in; // slave edges in active sense
  logic go; // start condition
  logic slv_sel; // slave selected
  logic fs_in; // frame pulse seen
  logic done; // word complete this cycle
  logic tx_pend_reg, tx_pend_next; // word waiting to go
  spcfg_div u_div (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(en_reg & master & busy_reg & ~clk_rel),
    .pri_code(one_reg[PRI_LSB +: 2]),
    .sec_code(one_reg[SEC_LSB +: 3]),
    .tick(tick)
  );
  // next state of engine
  always_comb begin
    last_ph = width16 ? 6'h1f : 6'h0f;
    act_in = s_sck ^ cpol;
    lead = (act_in != (sck_d_reg ^ cpol)) & act_in;
    trail = (act_in != (sck_d_reg ^ cpol)) & ~act_in;
    fs_in = (s_sel == frm_pol);
    slv_sel = frm_en ? 1'b1 : (~sel_en | ~s_sel);
    go = ~busy_reg & en_reg & (master ? (tx_pend_reg & ~frm_dir) :
         (frm_en ? (frm_dir & fs_in) : 1'b1));
    busy_next = busy_reg;
    ph_next = ph_reg;
    sh_next = sh_reg;
    sck_next = sck_reg;
    sdo_next = sdo_reg;
    fs_next = fs_reg;
    pend_next = pend_reg;
    rx_next = rx_reg;
    done = 1'b0;
    if (!en_reg) begin
      busy_next = 1'b0;
      sck_next = 1'b0;
      fs_next = 1'b0;
    end else if (go) begin
      busy_next = master | frm_en;
      ph_next = 6'h00;
      sh_next = width16 ? tx_reg : {tx_reg[7:0], 8'h00};
      sdo_next = width16 ? tx_reg[15] : tx_reg[7];
      fs_next = master & frm_en;
      if (!master && !frm_en) begin
        busy_next = 1'b1;
      end
    end else if (busy_reg && master && tick) begin
      ph_next = ph_reg + 6'h01;
      sck_next = ~sck_reg;
      if (!sck_reg) begin
        // entering active half: mid-bit sample unless deferred
        if (input_sample_phase) begin
          pend_next = 1'b1;
        end else begin
          sh_next = {sh_reg[14:0], s_sdi};
        end
        if (edge_sel == 1'b0 && ph_reg != 6'h00) begin
          sdo_next = sh_reg[15];
        end
        // frame pulse held through the first bit, then dropped
        if (ph_reg == 6'h00 && frm_edge) begin
          fs_next = 1'b1;
        end else if (ph_reg >= 6'h01) begin
          fs_next = 1'b0;
        end
      end else begin
        if (pend_reg) begin
          sh_next = {sh_reg[14:0], s_sdi};
          pend_next = 1'b0;
        end
        if (edge_sel) begin
          sdo_next = sh_next[15];
        end
      end
      if (ph_reg == last_ph) begin
        busy_next = 1'b0;
        sck_next = 1'b0;
        done = 1'b1;
      end
    end else if (busy_reg && !master) begin
      if (!slv_sel) begin
        ph_next = 6'h00;
      end else if (lead) begin
        sh_next = {sh_reg[14:0], s_sdi};
        ph_next = ph_reg + 6'h01;
        if (ph_reg[4:0] == last_ph[5:1]) begin
          done = 1'b1;
          ph_next = 6'h00;
        end
      end else if (trail) begin
        sdo_next = sh_reg[15];
      end
    end
    if (done) begin
      rx_next = width16 ? sh_next : {8'h00, sh_next[7:0]};
    end
  end
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  // receive full is set here only; the engine just raises done
  always_comb begin
    one_next = one_reg;
    two_next = two_reg;
    en_next = en_reg;
    tx_next = tx_reg;
    tx_pend_next = tx_pend_reg;
    rdata_next = 16'h0000;
    if (go && master) begin
      tx_pend_next = 1'b0;
    end
    if (wr_stb) begin
      unique case (addr)
        CTRL_ONE_ADDR: one_next = wdata & CTRL_ONE_MASK;
        CTRL_TWO_ADDR: two_next = wdata & CTRL_TWO_MASK;
        STATUS_ADDR: en_next = wdata[EN_BIT];
        TX_ADDR: begin
          tx_next = wdata;
          tx_pend_next = 1'b1;
        end
        default: ;
      endcase
    end
    if (rd_stb) begin
      unique case (addr)
        CTRL_ONE_ADDR: rdata_next = one_reg;
        CTRL_TWO_ADDR: rdata_next = two_reg;
        STATUS_ADDR: rdata_next = {en_reg, 13'h0000, busy_reg, rxf_reg};
        RX_ADDR: rdata_next = rx_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
    // set wins over the read clear
    rxf_next = done | (rxf_reg & ~(rd_stb && addr == RX_ADDR));
  end
  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  logic sck_o_n, sck_oe_n_n, sdo_oe_n_n, sel_o_n, sel_oe_n_n;
  always_comb begin
    sck_o_n = sck_reg ^ cpol;
    sck_oe_n_n = ~(en_reg & master & ~clk_rel);
    sdo_oe_n_n = ~(en_reg & ~dout_rel);
    sel_o_n = fs_reg ? frm_pol : ~frm_pol;
    sel_oe_n_n = ~(en_reg & frm_en & ~frm_dir);
  end
  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      one_reg <= CTRL_RESET;
      two_reg <= CTRL_RESET;
      en_reg <= 1'b0;
      tx_reg <= 16'h0000;
      tx_pend_reg <= 1'b0;
      rx_reg <= 16'h0000;
      rxf_reg <= 1'b0;
      rdata <= 16'h0000;
      busy_reg <= 1'b0;
      ph_reg <= 6'h00;
      sh_reg <= 16'h0000;
      sck_reg <= 1'b0;
      sdo_reg <= 1'b0;
      fs_reg <= 1'b0;
      pend_reg <= 1'b0;
      sck_out <= 1'b0;
      sck_oe_n <= 1'b1;
      sdo_out <= 1'b0;
      sdo_oe_n <= 1'b1;
      sel_out <= 1'b1;
      sel_oe_n <= 1'b1;
    end else begin
      one_reg <= one_next;
      two_reg <= two_next;
      en_reg <= en_next;
      tx_reg <= tx_next;
      tx_pend_reg <= tx_pend_next;
      rx_reg <= rx_next;
      rxf_reg <= rxf_next;
      rdata <= rdata_next;
      busy_reg <= busy_next;
      ph_reg <= ph_next;
      sh_reg <= sh_next;
      sck_reg <= sck_next;
      sdo_reg <= sdo_next;
      fs_reg <= fs_next;
      pend_reg <= pend_next;
      sck_out <= sck_o_n;
      sck_oe_n <= sck_oe_n_n;
      sdo_out <= sdo_next;
      sdo_oe_n <= sdo_oe_n_n;
      sel_out <= sel_o_n;
      sel_oe_n <= sel_oe_n_n;
    end
  end
endmodule
`default_nettype wire

// [rtl/spcfg_pkg.sv]
// package: register map, field positions and reset values of the serial port config block
package spcfg_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] CTRL_ONE_ADDR = 4'h0; // control one
  localparam logic [3:0] CTRL_TWO_ADDR = 4'h1; // control two
  localparam logic [3:0] STATUS_ADDR = 4'h2; // module enable and live state
  localparam logic [3:0] TX_ADDR = 4'h3; // transmit word
  localparam logic [3:0] RX_ADDR = 4'h4; // received word
  // ---------------------------------------------------------------
  // control one fields
  // ---------------------------------------------------------------
  localparam int CLK_REL_BIT = 12;
  localparam int DOUT_REL_BIT = 11;
  localparam int WIDTH_BIT = 10;
  localparam int SMP_BIT = 9;
  localparam int EDGE_BIT = 8;
  localparam int SEL_EN_BIT = 7;
  localparam int POL_BIT = 6;
  localparam int MASTER_BIT = 5;
  localparam int SEC_LSB = 2;
  localparam int PRI_LSB = 0;
  localparam logic [15:0] CTRL_ONE_MASK = 16'h1fff; // 15..13 read zero
  // ---------------------------------------------------------------
  // control two fields
  // ---------------------------------------------------------------
  localparam int FRM_EN_BIT = 15;
  localparam int FRM_DIR_BIT = 14;
  localparam int FRM_POL_BIT = 13;
  localparam int FRM_EDGE_BIT = 1;
  localparam logic [15:0] CTRL_TWO_MASK = 16'he002; // 12..2 and 0 zero
  // ---------------------------------------------------------------
  // status fields
  // ---------------------------------------------------------------
  localparam int EN_BIT = 15;
  localparam int BUSY_BIT = 1;
  localparam int RXF_BIT = 0;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] STATUS_WMASK = 16'h8000;
endpackage

// [rtl/spcfg_div.sv]
// module: two-stage prescaler giving one-cycle half bit period enables
`timescale 1ns/1ps
`default_nettype none
module spcfg_div (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic run,
  input wire logic [1:0] pri_code,
  input wire logic [2:0] sec_code,
  output logic tick
);
  import spcfg_pkg::*;
  // ---------------------------------------------------------------
  // prescale counter
  // ---------------------------------------------------------------
  logic [8:0] cnt_reg; // cycles since last tick
  logic [8:0] cnt_next;
  logic [8:0] limit; // ratio minus one
  logic [6:0] pri_ratio; // 1,4,16,64
  logic [3:0] sec_ratio; // 1..8
  logic tick_next;
  // decode ratios and count
  always_comb begin
    unique case (pri_code)
      2'h3: pri_ratio = 7'h01;
      2'h2: pri_ratio = 7'h04;
      2'h1: pri_ratio = 7'h10;
      default: pri_ratio = 7'h40;
    endcase
    sec_ratio = 4'h8 - {1'b0, sec_code}; // 111 -> 1, 000 -> 8
    limit = 9'(pri_ratio * sec_ratio) - 9'h001;
    tick_next = 1'b0;
    cnt_next = cnt_reg;
    if (!run) begin
      cnt_next = 9'h000;
    end else if (cnt_reg >= limit) begin
      cnt_next = 9'h000;
      tick_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 9'h001;
    end
  end
  // register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 9'h000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick <= tick_next;
    end
  end
endmodule
`default_nettype wire

// [test/spcfg_checker.sv]
// checker: port-level assertions of the serial port config block
`timescale 1ns/1ps
`default_nettype none
module spcfg_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [15:0] rdata,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic sdo_oe_n,
  input wire logic sel_oe_n
);
  import spcfg_pkg::*;
  logic [15:0] c1_reg, c1_next, c2_reg, c2_next; // shadow controls
  logic en_reg, en_next, seen_reg, seen_next, sck_reg; // shadow state
  logic [9:0] gap_reg, gap_next, ratio; // clock pin spacing
  // shadow of writes; a write restarts spacing, so idle moves pass
  always_comb begin
    c1_next = c1_reg;
    c2_next = c2_reg;
    en_next = en_reg;
    if (wr_stb && addr == CTRL_ONE_ADDR) c1_next = wdata & CTRL_ONE_MASK;
    if (wr_stb && addr == CTRL_TWO_ADDR) c2_next = wdata & CTRL_TWO_MASK;
    if (wr_stb && addr == STATUS_ADDR) en_next = wdata[EN_BIT];
    seen_next = !wr_stb && (seen_reg || sck_out != sck_reg);
    gap_next = (sck_out != sck_reg) ? 10'h001
             : gap_reg + {9'h000, gap_reg != 10'h3ff};
    ratio = 10'(8 - c1_reg[SEC_LSB+:3]) << (6 - 2 * c1_reg[1:0]);
  end
  // register the shadow
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      c1_reg <= CTRL_RESET;
      c2_reg <= CTRL_RESET;
      en_reg <= 1'b0;
      seen_reg <= 1'b0;
      gap_reg <= 10'h000;
      sck_reg <= 1'b0;
    end else begin
      c1_reg <= c1_next;
      c2_reg <= c2_next;
      en_reg <= en_next;
      seen_reg <= seen_next;
      gap_reg <= gap_next;
      sck_reg <= sck_out;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  chk_rd_one: assert property (rd_stb && addr == CTRL_ONE_ADDR |=>
    rdata == c1_reg) else $error("control one readback wrong");
  chk_rd_two: assert property (rd_stb && addr == CTRL_TWO_ADDR |=>
    rdata == c2_reg) else $error("control two readback wrong");
  chk_rd_unmapped: assert property (rd_stb && addr > RX_ADDR |=>
    rdata == 16'h0000) else $error("unmapped read not zero");
  chk_off_pins: assert property (!en_reg [*2] |->
    sck_oe_n && sdo_oe_n && sel_oe_n) else $error("pin driven while off");
  chk_master_clk: assert property (en_reg && c1_reg[MASTER_BIT] &&
    !c1_reg[CLK_REL_BIT] [*2] |-> !sck_oe_n) else $error("no master clock");
  chk_slave_clk: assert property (!c1_reg[MASTER_BIT] [*2] |->
    sck_oe_n) else $error("slave drives clock pin");
  chk_clk_rel: assert property (c1_reg[CLK_REL_BIT] [*3] |->
    sck_oe_n && $stable(sck_out)) else $error("released clock moves");
  chk_dout_rel: assert property (c1_reg[DOUT_REL_BIT] [*2] |->
    sdo_oe_n) else $error("released data pin driven");
  chk_frame_out: assert property (en_reg && c1_reg[MASTER_BIT] &&
    c2_reg[FRM_EN_BIT] && !c2_reg[FRM_DIR_BIT] [*2] |-> !sel_oe_n)
    else $error("frame pulse not driven");
  chk_clk_spacing: assert property (seen_reg && sck_out != sck_reg |->
    gap_reg >= ratio) else $error("clock edges too close");
  cover property (seen_reg && sck_out != sck_reg);
  cover property (rd_stb && addr == CTRL_TWO_ADDR);
  cover property (!sel_oe_n);
endmodule
bind spcfg_top spcfg_checker i_chk (.ref_clk, .rstn, .addr, .wdata,
  .wr_stb, .rd_stb, .rdata, .sck_out, .sck_oe_n, .sdo_oe_n, .sel_oe_n);
`default_nettype wire

// [test/spcfg_peer.sv]
// partner: serial peripheral on the far side of the four pins
`timescale 1ns/1ps
`default_nettype none
module spcfg_peer (
  input wire logic ref_clk,
  input wire logic sck_out,
  input wire logic sck_oe_n,
  input wire logic sdo_out,
  input wire logic sel_out,
  input wire logic sel_oe_n,
  output logic sck_pin,
  output logic sel_pin,
  output logic sdi_pin
);
  logic [15:0] word; // echo register, shifted on clock moves
  logic sck_d; // last seen clock level
  // undriven clock pin rests low; select pin has a pull-up
  assign sck_pin = sck_oe_n ? 1'b0 : sck_out;
  assign sel_pin = sel_oe_n ? 1'b1 : sel_out;
  initial begin
    word = 16'h5a3c;
    sck_d = 1'b0;
    sdi_pin = 1'b0;
  end
  // no clock: data line keeps moving so nothing stale looks valid
  always @(posedge ref_clk) begin
    sck_d <= sck_pin;
    if (sck_pin != sck_d) begin
      sdi_pin <= word[15];
      word <= {word[14:0], sdo_out};
    end else if (sck_oe_n) begin
      sdi_pin <= ~sdi_pin;
    end
  end
endmodule
`default_nettype wire

// [test/test_spcfg_top.sv]
// testbench: registers, pin modes and transfers of the serial port unit
`timescale 1ns/1ps
`default_nettype none
module test_spcfg_top;
  import spcfg_pkg::*;
  logic ref_clk, rstn, wr_stb, rd_stb, sck_in, sdi_in, sel_in, rd_pend;
  logic sck_out, sck_oe_n, sdo_out, sdo_oe_n, sel_out, sel_oe_n;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, tmp;
  logic [15:0] exp_q[$]; // expected read words, oldest first
  int fails, checked;
  int pr[4] = '{3, 2, 1, 0}; // primary codes per transfer
  int sc[4] = '{6, 0, 5, 7}; // secondary codes per transfer
  int pf[4] = '{64, 16, 4, 1}; // primary ratio by code
  spcfg_top i_dut (.ref_clk, .rstn, .addr, .wdata, .wr_stb, .rd_stb,
    .rdata, .sck_in, .sck_out, .sck_oe_n, .sdo_out, .sdo_oe_n, .sdi_in,
    .sel_in, .sel_out, .sel_oe_n);
  spcfg_peer i_peer (.ref_clk, .sck_out, .sck_oe_n, .sdo_out, .sel_out,
    .sel_oe_n, .sck_pin(sck_in), .sel_pin(sel_in), .sdi_pin(sdi_in));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_pin(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask
  // read data stands one cycle after the strobe only
  always @(posedge ref_clk) begin
    rd_pend <= rd_stb;
    if (rd_pend) cmp_word(rdata, exp_q.pop_front());
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge ref_clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_stb <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    rd_stb <= 1'b0;
  endtask
  task automatic pins(input logic ck, input logic dt, input logic sl);
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_pin(sck_oe_n, ck);
    cmp_pin(sdo_oe_n, dt);
    cmp_pin(sel_oe_n, sl);
  endtask
  // one word: each clock move spaced by the ratio, frame pulse if framed
  task automatic xfer(input int ratio, input int bits, input logic frm,
                      input logic pol);
    int n;
    int gap;
    logic last;
    logic act;
    n = 0;
    gap = 0;
    act = 1'b0;
    // a polarity write just before lands on the pin one edge later
    repeat (2) @(posedge ref_clk);
    #1 last = sck_out;
    wr(TX_ADDR, 16'($urandom));
    repeat (2 * bits * ratio + 100) begin
      @(posedge ref_clk);
      #1;
      gap++;
      if (sel_oe_n === 1'b0 && sel_out === pol) act = 1'b1;
      if (sck_out !== last) begin
        if (n > 0) cmp_word(16'(gap), 16'(ratio));
        n++;
        gap = 0;
        last = sck_out;
      end
    end
    cmp_word(16'(n), 16'(2 * bits));
    cmp_pin(act, frm);
    rd(STATUS_ADDR, 16'h8001);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    $display("[ERR] %0t run did not finish", $time);
    end_of_test();
  end
  initial begin
    {rstn, wr_stb, rd_stb, rd_pend, addr, wdata} = '0;
    fails = 0;
    checked = 0;
    void'($urandom(57));
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(CTRL_ONE_ADDR, CTRL_RESET);
    rd(CTRL_TWO_ADDR, CTRL_RESET);
    pins(1'b1, 1'b1, 1'b1);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      tmp = 16'($urandom);
      wr(CTRL_ONE_ADDR, tmp);
      rd(CTRL_ONE_ADDR, tmp & CTRL_ONE_MASK);
      tmp = 16'($urandom) & 16'hfffe;
      wr(CTRL_TWO_ADDR, tmp);
      rd(CTRL_TWO_ADDR, tmp & CTRL_TWO_MASK);
    end
    wr(4'hf, 16'hffff);
    rd(4'hf, 16'h0000);
    wr(CTRL_TWO_ADDR, 16'h0000);
    $display("register test done");
    for (int i = 0; i < 16; i++) begin
      tmp = 16'h0003 | 16'(i[0]) << MASTER_BIT | 16'(i[1]) << CLK_REL_BIT
          | 16'(i[2]) << DOUT_REL_BIT | 16'(i[3]) << POL_BIT;
      // an enabled slave sits busy waiting for a clock; disabling
      // between modes keeps that word from running as a master word
      wr(STATUS_ADDR, 16'h0000);
      wr(CTRL_ONE_ADDR, tmp);
      wr(STATUS_ADDR, 16'h8000);
      pins(!(i[0] && !i[1]), i[2], 1'b1);
      if (i[0] && !i[1]) cmp_pin(sck_out, i[3]);
    end
    $display("pin mode test done");
    for (int i = 0; i < 4; i++) begin
      tmp = 16'(pr[i]) | 16'(sc[i]) << SEC_LSB | 16'h0001 << MASTER_BIT
          | 16'(i[0]) << WIDTH_BIT | 16'(i[1]) << SMP_BIT
          | 16'(i[1]) << EDGE_BIT;
      wr(CTRL_ONE_ADDR, tmp);
      xfer(pf[pr[i]] * (8 - sc[i]), i[0] ? 16 : 8, 1'b0, 1'b0);
    end
    $display("transfer test done");
    for (int p = 0; p < 2; p++) begin
      wr(CTRL_TWO_ADDR, 16'h8000 | 16'(p) << FRM_POL_BIT
         | 16'(p) << FRM_EDGE_BIT);
      wr(CTRL_ONE_ADDR, 16'h003a);
      pins(1'b0, 1'b0, 1'b0);
      cmp_pin(sel_out, !p[0]);
      xfer(8, 8, 1'b1, p[0]);
    end
    wr(CTRL_TWO_ADDR, 16'hc000);
    pins(1'b0, 1'b0, 1'b1);
    wr(STATUS_ADDR, 16'h0000);
    pins(1'b1, 1'b1, 1'b1);
    $display("framed test done");
    end_of_test();
  end
endmodule
`default_nettype wire
